/* File: rtl/cpu_core_pkg.sv */
// Shared constants and carriers for the processor card core.
// Assumes a single 20 MHz system clock.
package cpu_core_pkg;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          ADDR_W         = 14;
  localparam int          PAGE_W         = 6;
  localparam int          BYTE_W         = 8;
  localparam int          STACK_DEPTH    = 8;
  localparam int          STACK_PTR_W    = 3;
  localparam int          NUM_LEVELS     = 8;
  localparam int          NUM_REGS       = 7;
  localparam logic [2:0]  REG_MEM_CODE   = 3'h7;
  localparam logic [2:0]  REG_PAGE_CODE  = 3'h5;
  localparam logic [2:0]  REG_BYTE_CODE  = 3'h6;
  localparam logic [2:0]  RTC_LEVEL      = 3'h7;
  localparam logic [13:0] VECTOR_STRIDE  = 14'h0008;
  localparam logic [13:0] RESET_VECTOR   = 14'h0000;
  localparam logic [2:0]  SP_RESET       = 3'h0;
  localparam logic [7:0]  IRQ_EN_RESET   = 8'h00;
  // Tick period in microseconds
  localparam int          RTC_PERIOD_US  = 10_000;
  localparam int          RTC_MIN_US     = 100;
  // One hour in microseconds does not fit a 32-bit int
  localparam longint      RTC_MAX_US     = longint'(3_600) * 1_000_000;
  localparam int          CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int          RTC_CYCLES     = RTC_PERIOD_US * CYC_PER_US;
  localparam int          RTC_CNT_W      = 37;

  // Flag indices
  localparam int          FLAG_C         = 0;
  localparam int          FLAG_Z         = 1;
  localparam int          FLAG_S         = 2;
  localparam int          FLAG_P         = 3;

  typedef enum logic [2:0] {
    OP_NONE, OP_ARITH, OP_LOGIC, OP_INCDEC, OP_LOAD
  } alu_kind_e;

  typedef enum logic [2:0] {
    FL_JUMP, FL_CALL, FL_RET, FL_RST
  } flow_kind_e;

  typedef struct packed {
    logic        valid;
    alu_kind_e   kind;
    logic [2:0]  dest;
    logic [7:0]  result;
    logic        carry;
  } exec_s;

  typedef struct packed {
    logic        valid;
    flow_kind_e  kind;
    logic        conditional;
    logic [1:0]  flag_sel;
    logic        flag_true;
    logic [13:0] target;
  } flow_s;

  typedef struct packed {
    logic        c;
    logic        z;
    logic        s;
    logic        p;
  } flags_s;
endpackage

/* File: rtl/return_stack.sv */
// Eight-entry program counter stack with wrap-around pointer.
// Assumes one push or pop per cycle from the core.
`timescale 1ns/100ps
`default_nettype none
module return_stack #(
  parameter int DEPTH = cpu_core_pkg::STACK_DEPTH,
  parameter int PTR_W = cpu_core_pkg::STACK_PTR_W
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           push,
  input  wire logic                           pop,
  input  wire logic                           load,
  input  wire logic [cpu_core_pkg::ADDR_W-1:0] wdata,
  output logic      [cpu_core_pkg::ADDR_W-1:0] pc,
  output logic      [PTR_W-1:0]                sp
);
  import cpu_core_pkg::*;

  logic [ADDR_W-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0]  sp_r;
  logic [PTR_W-1:0]  sp_nxt;

  always_comb begin
    sp_nxt = sp_r;
    if (push) begin
      sp_nxt = sp_r - PTR_W'(1);
    end else if (pop) begin
      sp_nxt = sp_r + PTR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= RESET_VECTOR;
      end
    end else if (push || load) begin
      mem_r[sp_nxt] <= wdata;
    end
  end

  assign pc = mem_r[sp_r];
  assign sp = sp_r;
endmodule
`default_nettype wire

/* File: rtl/rtc_tick.sv */
// Periodic real-time tick from the system clock.
// Assumes period_cycles is held steady by the configuring logic.
`timescale 1ns/100ps
`default_nettype none
module rtc_tick #(
  parameter int CNT_W = cpu_core_pkg::RTC_CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [CNT_W-1:0] period_cycles,
  output logic                  tick
);
  import cpu_core_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + CNT_W'(1);
    if (cnt_r + CNT_W'(1) >= period_cycles) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule
`default_nettype wire

/* File: rtl/cpu_card_core.sv */
// Processor card core state: working registers, memory address, stack,
// flags, vectored interrupts and real-time tick.
// Assumes an external sequencer presents one decoded operation per cycle.
`timescale 1ns/100ps
`default_nettype none
module cpu_card_core #(
  parameter int RTC_PERIOD = cpu_core_pkg::RTC_CYCLES
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           power_up_det,
  input  wire logic                           init_req,
  input  wire logic [cpu_core_pkg::NUM_LEVELS-1:0] irq_req,
  input  wire logic                           rtc_to_level7,
  input  wire logic [cpu_core_pkg::NUM_LEVELS-1:1] irq_enable,
  input  wire logic                           irq_mask_all,
  input  wire logic [cpu_core_pkg::RTC_CNT_W-1:0]  rtc_period_cycles,
  input  wire logic                           rtc_use_default,
  input  wire cpu_core_pkg::exec_s            exec_op,
  input  wire cpu_core_pkg::flow_s            flow_op,
  input  wire logic                           step_done,
  input  wire logic [2:0]                     rd_sel,
  input  wire logic [7:0]                     mem_rdata,
  input  wire logic                           addr_from_mem,
  output logic      [7:0]                     rd_data,
  output logic      [cpu_core_pkg::ADDR_W-1:0] pc,
  output logic      [cpu_core_pkg::STACK_PTR_W-1:0] stack_ptr,
  output cpu_core_pkg::flags_s                flags,
  output logic                                mem_wr,
  output logic      [7:0]                     mem_wdata,
  output logic      [cpu_core_pkg::ADDR_W-1:0] bus_address,
  output logic                                bus_address_line_low,
  output logic                                bus_address_line_top,
  output logic      [cpu_core_pkg::NUM_LEVELS-1:0] irq_ack,
  output logic                                rtc_tick_out
);
  import cpu_core_pkg::*;

  function automatic logic [13:0] vector_of(input logic [2:0] lvl);
    vector_of = 14'({11'h000, lvl}) * VECTOR_STRIDE;
  endfunction

  function automatic logic flag_pick(input flags_s f,
                                     input logic [1:0] sel);
    case (sel)
      2'h0:    flag_pick = f.c;
      2'h1:    flag_pick = f.z;
      2'h2:    flag_pick = f.s;
      default: flag_pick = f.p;
    endcase
  endfunction

  // Synchronised pins
  logic [NUM_LEVELS-1:0] irq_s1_r;
  logic [NUM_LEVELS-1:0] irq_s2_r;
  logic [1:0]            pwr_s_r;
  logic [1:0]            init_s_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      pwr_s_r  <= '0;
      init_s_r <= '0;
    end else begin
      irq_s1_r <= irq_req;
      irq_s2_r <= irq_s1_r;
      pwr_s_r  <= {pwr_s_r[0], power_up_det};
      init_s_r <= {init_s_r[0], init_req};
    end
  end

  // Real-time tick
  logic [RTC_CNT_W-1:0] rtc_period;
  logic                 rtc_tick;

  assign rtc_period = rtc_use_default ? RTC_CNT_W'(RTC_PERIOD)
                                      : rtc_period_cycles;

  rtc_tick #(
    .CNT_W         (RTC_CNT_W)
  ) u_rtc (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .period_cycles (rtc_period),
    .tick          (rtc_tick)
  );

  // Working registers and flags
  logic [7:0] regs_r   [NUM_REGS];
  logic [7:0] regs_nxt [NUM_REGS];
  flags_s     flags_r;
  flags_s     flags_nxt;
  logic       mem_wr_r;
  logic       mem_wr_nxt;
  logic [7:0] mem_wdata_r;
  logic [7:0] mem_wdata_nxt;

  always_comb begin
    regs_nxt      = regs_r;
    flags_nxt     = flags_r;
    mem_wr_nxt    = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    if (exec_op.valid) begin
      if (exec_op.dest == REG_MEM_CODE) begin
        mem_wr_nxt    = 1'b1;
        mem_wdata_nxt = exec_op.result;
      end else begin
        regs_nxt[exec_op.dest] = exec_op.result;
      end
      if (exec_op.kind != OP_LOAD && exec_op.kind != OP_NONE) begin
        flags_nxt.z = (exec_op.result == 8'h00);
        flags_nxt.s = exec_op.result[7];
        flags_nxt.p = ~^exec_op.result;
        case (exec_op.kind)
          OP_ARITH: flags_nxt.c = exec_op.carry;
          OP_LOGIC: flags_nxt.c = 1'b0;
          default:  flags_nxt.c = flags_r.c;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= 8'h00;
      end
      flags_r     <= '0;
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= 8'h00;
    end else begin
      regs_r      <= regs_nxt;
      flags_r     <= flags_nxt;
      mem_wr_r    <= mem_wr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  always_comb begin
    rd_data = mem_rdata;
    if (rd_sel != REG_MEM_CODE) begin
      rd_data = regs_r[rd_sel];
    end
  end

  // Interrupt arbitration
  logic [NUM_LEVELS-1:0] pending;
  logic                  take_irq;
  logic [2:0]            take_lvl;
  logic                  in_first_r;
  logic                  in_first_nxt;
  logic [NUM_LEVELS-1:0] ack_r;
  logic [NUM_LEVELS-1:0] ack_nxt;

  always_comb begin
    pending = irq_s2_r;
    if (rtc_to_level7) begin
      pending[RTC_LEVEL] = rtc_tick;
    end
    pending[NUM_LEVELS-1:1] = pending[NUM_LEVELS-1:1] & irq_enable
                              & {(NUM_LEVELS-1){~irq_mask_all}};
    pending[0] = irq_s2_r[0] | pwr_s_r[1] | init_s_r[1];
    take_lvl = 3'h0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        take_lvl = 3'(i);
      end
    end
    take_irq = (|pending) && step_done && !in_first_r;
  end

  // Program flow
  logic              br_ok;
  logic              st_push;
  logic              st_pop;
  logic              st_load;
  logic [ADDR_W-1:0] st_wdata;
  logic [ADDR_W-1:0] pc_now;

  always_comb begin
    st_push      = 1'b0;
    st_pop       = 1'b0;
    st_load      = 1'b0;
    st_wdata     = pc_now;
    in_first_nxt = in_first_r;
    ack_nxt      = '0;
    br_ok = !flow_op.conditional ||
            (flag_pick(flags_r, flow_op.flag_sel) == flow_op.flag_true);
    if (take_irq) begin
      st_push  = 1'b1;
      st_wdata = vector_of(take_lvl);
      in_first_nxt = 1'b1;
      ack_nxt[take_lvl] = 1'b1;
    end else if (flow_op.valid && br_ok) begin
      case (flow_op.kind)
        FL_CALL, FL_RST: begin
          st_push  = 1'b1;
          st_wdata = flow_op.target;
        end
        FL_RET:  st_pop = 1'b1;
        FL_JUMP: begin
          st_load  = 1'b1;
          st_wdata = flow_op.target;
        end
        default: st_load = 1'b0;
      endcase
    end
    if (!take_irq && step_done) begin
      in_first_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_first_r <= 1'b0;
      ack_r      <= '0;
    end else begin
      in_first_r <= in_first_nxt;
      ack_r      <= ack_nxt;
    end
  end

  return_stack #(
    .DEPTH   (STACK_DEPTH),
    .PTR_W   (STACK_PTR_W)
  ) u_stack (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .push    (st_push),
    .pop     (st_pop),
    .load    (st_load),
    .wdata   (st_wdata),
    .pc      (pc_now),
    .sp      (stack_ptr)
  );

  // General address register
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;

  always_comb begin
    addr_nxt = addr_from_mem
             ? {regs_r[REG_PAGE_CODE][PAGE_W-1:0], regs_r[REG_BYTE_CODE]}
             : pc_now;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= RESET_VECTOR;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  assign pc                   = pc_now;
  assign flags                = flags_r;
  assign mem_wr               = mem_wr_r;
  assign mem_wdata            = mem_wdata_r;
  assign bus_address          = addr_r;
  // Bus lines are active low on the backplane
  assign bus_address_line_low = ~addr_r[0];
  assign bus_address_line_top = ~addr_r[ADDR_W-1];
  assign irq_ack              = ack_r;
  assign rtc_tick_out         = rtc_tick;
endmodule
`default_nettype wire

/* File: verification/cpu_card_core_asserts.sv */
// Concurrent checks on the processor card core ports.
// Assumes the core package is compiled first; bound onto the core below.
`timescale 1ns/100ps
`default_nettype none
module cpu_card_core_asserts (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 step_done,
  input wire cpu_core_pkg::exec_s  exec_op,
  input wire cpu_core_pkg::flow_s  flow_op,
  input wire logic [2:0]           rd_sel,
  input wire logic [7:0]           mem_rdata,
  input wire logic [7:0]           rd_data,
  input wire logic [13:0]          pc,
  input wire logic [2:0]           stack_ptr,
  input wire cpu_core_pkg::flags_s flags,
  input wire logic [13:0]          bus_address,
  input wire logic                 bus_address_line_low,
  input wire logic                 bus_address_line_top,
  input wire logic [7:0]           irq_ack,
  input wire logic                 rtc_tick_out
);
  import cpu_core_pkg::*;
  logic [13:0] ack_vec;
  logic        ftest;
  always_comb begin
    ack_vec = 14'h0000;
    for (int i = 0; i < 8; i++) begin
      if (irq_ack[i]) begin
        ack_vec = VECTOR_STRIDE * 14'(i);
      end
    end
  end
  assign ftest = flags[2'd3 - flow_op.flag_sel];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Low step_done keeps interrupts from stealing the flow cycle
  sequence s_flow(k);
    flow_op.valid && flow_op.kind == k && !step_done && !flow_op.conditional;
  endsequence
  a_call_push: assert property (s_flow(FL_CALL) |=> stack_ptr ==
    $past(stack_ptr) - 3'h1 && pc == $past(flow_op.target))
    else $error("call did not push target");
  a_ret_pop: assert property (s_flow(FL_RET) |=>
    stack_ptr == $past(stack_ptr) + 3'h1) else $error("return did not pop");
  a_cond_refused: assert property (flow_op.valid && flow_op.conditional &&
    !step_done && ftest != flow_op.flag_true |=> $stable(stack_ptr) &&
    $stable(pc)) else $error("false condition still branched");
  a_ack_vector: assert property (irq_ack != 8'h00 |-> $onehot(irq_ack) &&
    pc == ack_vec && stack_ptr == $past(stack_ptr) - 3'h1)
    else $error("acknowledge without matching vector entry");
  a_ack_single: assert property (irq_ack != 8'h00 |=> irq_ack == 8'h00)
    else $error("acknowledge longer than one cycle");
  a_arith_flags: assert property (exec_op.valid && exec_op.kind == OP_ARITH
    |=> flags == {$past(exec_op.carry), $past(exec_op.result) == 8'h00,
    $past(exec_op.result[7]), ~^$past(exec_op.result)})
    else $error("arithmetic flags wrong");
  a_logic_carry: assert property (exec_op.valid && exec_op.kind == OP_LOGIC
    |=> !flags.c && flags.p == ~^$past(exec_op.result))
    else $error("logic op left carry set");
  a_incdec_carry: assert property (exec_op.valid &&
    exec_op.kind == OP_INCDEC |=> flags.c == $past(flags.c) &&
    flags.s == $past(exec_op.result[7])) else $error("incdec flags wrong");
  a_load_keeps: assert property (exec_op.valid && exec_op.kind == OP_LOAD
    |=> $stable(flags)) else $error("load changed flags");
  a_line_levels: assert property (bus_address_line_low == !bus_address[0] &&
    bus_address_line_top == !bus_address[13]) else $error("bus lines wrong");
  a_mem_read: assert property (rd_sel == REG_MEM_CODE |->
    rd_data == mem_rdata) else $error("code 7 not memory byte");
  a_tick_pulse: assert property (rtc_tick_out |=> !rtc_tick_out)
    else $error("tick longer than one cycle");
endmodule
bind cpu_card_core cpu_card_core_asserts u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .step_done(step_done),
  .exec_op(exec_op), .flow_op(flow_op), .rd_sel(rd_sel),
  .mem_rdata(mem_rdata), .rd_data(rd_data), .pc(pc),
  .stack_ptr(stack_ptr), .flags(flags), .bus_address(bus_address),
  .bus_address_line_low(bus_address_line_low),
  .bus_address_line_top(bus_address_line_top), .irq_ack(irq_ack),
  .rtc_tick_out(rtc_tick_out));
`default_nettype wire

/* File: verification/mem_card_model.sv */
// Behavioural memory card answering the byte at the bus address.
// Assumes a settled address; the read path has no wait states.
`timescale 1ns/100ps
`default_nettype none
module mem_card_model (
  input  wire logic [13:0] bus_address,
  output logic      [7:0]  mem_rdata
);
  // Pattern content lets the bench predict bytes without a table
  assign mem_rdata = bus_address[7:0] ^ {2'h0, bus_address[13:8]};
endmodule
`default_nettype wire

/* File: verification/cpu_card_core_tb_top.sv */
// Self-checking bench for the processor card core.
// Assumes the memory card model answers reads and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cpu_card_core_tb_top;
  import cpu_core_pkg::*;
  typedef struct packed {
    alu_kind_e  kind;
    logic [7:0] res;
    logic       cy;
    logic [3:0] fl;
  } row_s;
  logic        clk_sys, rst_n, power_up_det, init_req, rtc_to_level7;
  logic        irq_mask_all, rtc_use_default, step_done, addr_from_mem;
  logic        line_low, line_top, rtc_tick_out, tk, mem_wr;
  logic [7:0]  irq_req, mem_rdata, rd_data, irq_ack, mem_wdata;
  logic [7:1]  irq_enable;
  logic [36:0] rtc_period_cycles;
  logic [2:0]  rd_sel, stack_ptr;
  logic [13:0] pc, bus_address, tgt;
  exec_s       exec_op;
  flow_s       flow_op;
  flags_s      flags;
  row_s        rows [7];
  int          err_count, n_tests, i, k, t0, t1;
  // Short default period keeps the default-select path reachable
  localparam int RTC_SIM = 16;
  cpu_card_core #(.RTC_PERIOD(RTC_SIM)) u_dut (.clk_sys(clk_sys),
    .rst_n(rst_n),
    .power_up_det(power_up_det), .init_req(init_req), .irq_req(irq_req),
    .rtc_to_level7(rtc_to_level7), .irq_enable(irq_enable),
    .irq_mask_all(irq_mask_all), .rtc_period_cycles(rtc_period_cycles),
    .rtc_use_default(rtc_use_default), .exec_op(exec_op),
    .flow_op(flow_op), .step_done(step_done), .rd_sel(rd_sel),
    .mem_rdata(mem_rdata), .addr_from_mem(addr_from_mem),
    .rd_data(rd_data), .pc(pc), .stack_ptr(stack_ptr), .flags(flags),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .bus_address(bus_address),
    .bus_address_line_low(line_low), .bus_address_line_top(line_top),
    .irq_ack(irq_ack), .rtc_tick_out(rtc_tick_out));
  mem_card_model u_mem (.bus_address(bus_address), .mem_rdata(mem_rdata));
  // An op stays raised until the next task drops or replaces it
  task automatic step();
    exec_op.valid = 1'b0;
    flow_op.valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic exe(alu_kind_e kd, logic [2:0] d, logic [7:0] r, logic c);
    flow_op.valid = 1'b0;
    exec_op = '{1'b1, kd, d, r, c};
    @(posedge clk_sys);
    #1;
  endtask
  task automatic flow(flow_kind_e kd, logic cn, logic [1:0] fs, logic ft,
                      logic [13:0] t);
    exec_op.valid = 1'b0;
    flow_op = '{1'b1, kd, cn, fs, ft, t};
    @(posedge clk_sys);
    #1;
  endtask
  // Requests are dropped and let settle so a stale one is not retaken
  task automatic irq_try(logic [7:0] exp_ack, logic [13:0] exp_pc);
    logic [7:0] seen;
    logic [2:0] sp0;
    sp0 = stack_ptr;
    seen = 8'h00;
    step_done = 1'b1;
    for (int n = 0; n < 20 && seen == 8'h00; n++) begin
      step();
      seen = irq_ack;
    end
    step_done = 1'b0;
    irq_req = 8'h00;
    {init_req, power_up_det, rtc_to_level7} = 3'h0;
    repeat (4) step();
    `CHK("irq_ack", exp_ack, seen)
    `CHK("vector", exp_pc, pc)
    `CHK("irq_sp", exp_ack != 8'h00 ? sp0 - 3'h1 : sp0, stack_ptr)
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end
  initial begin
    rows = '{'{OP_ARITH, 8'h00, 1'b1, 4'hd}, '{OP_ARITH, 8'h81, 1'b0, 4'h3},
             '{OP_LOGIC, 8'h07, 1'b1, 4'h0}, '{OP_INCDEC, 8'h80, 1'b1, 4'h2},
             '{OP_ARITH, 8'hff, 1'b1, 4'hb}, '{OP_INCDEC, 8'h00, 1'b0, 4'hd},
             '{OP_LOAD, 8'h55, 1'b0, 4'hd}};
    {rst_n, power_up_det, init_req, rtc_to_level7, irq_mask_all} = 5'h0;
    {step_done, addr_from_mem, rtc_use_default} = 3'h0;
    {irq_req, irq_enable, rd_sel, exec_op, flow_op} = '0;
    rtc_period_cycles = 37'd10;
    {err_count, n_tests} = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    step();
    `CHK("rst_pc", 14'h0000, pc)
    `CHK("rst_sp", 3'h0, stack_ptr)
    `CHK("rst_line", 1'b1, line_low)
    for (i = 0; i < 7; i++) begin
      exe(rows[i].kind, 3'h0, rows[i].res, rows[i].cy);
      `CHK("flags", rows[i].fl, flags)
    end
    for (i = 0; i < 7; i++) exe(OP_LOAD, i[2:0], 8'h30 + i[7:0], 1'b0);
    for (i = 0; i < 7; i++) begin
      rd_sel = i[2:0];
      #1 `CHK("reg", 8'h30 + i[7:0], rd_data)
    end
    // Top page bits must be dropped from the address
    exe(OP_LOAD, REG_PAGE_CODE, 8'hf5, 1'b0);
    addr_from_mem = 1'b1;
    rd_sel = REG_MEM_CODE;
    step();
    `CHK("addr", 14'h3536, bus_address)
    `CHK("line_top", 1'b0, line_top)
    `CHK("mem_byte", 8'h03, rd_data)
    addr_from_mem = 1'b0;
    exe(OP_LOAD, REG_MEM_CODE, 8'ha5, 1'b0);
    `CHK("mem_wr", 1'b1, mem_wr)
    `CHK("mem_wdata", 8'ha5, mem_wdata)
    step();
    `CHK("mem_wr_end", 1'b0, mem_wr)
    for (k = 7; k <= 8; k++) begin
      for (i = 1; i <= k; i++) begin
        flow(i[0] ? FL_RST : FL_CALL, 1'b0, 2'h0, 1'b0, 14'h0100 + 14'(i));
        `CHK("call_pc", 14'h0100 + 14'(i), pc)
      end
      for (i = k - 1; i >= 0; i--) begin
        flow(FL_RET, 1'b0, 2'h0, 1'b0, 14'h0000);
        tgt = i > 0 ? 14'h0100 + 14'(i) : (k == 8 ? 14'h0108 : 14'h0000);
        `CHK("ret_pc", tgt, pc)
      end
    end
    `CHK("ret_sp", 3'h0, stack_ptr)
    for (i = 0; i < 8; i++) begin
      tgt = pc;
      tk = ((4'hd >> (2'd3 - i[1:0])) & 4'h1) == {3'h0, i[2]};
      flow(FL_JUMP, 1'b1, i[1:0], i[2], 14'h0200 + 14'(i));
      `CHK("cond", tk ? 14'h0200 + 14'(i) : tgt, pc)
    end
    flow(FL_CALL, 1'b1, 2'h2, 1'b0, 14'h0300);
    flow(FL_RET, 1'b1, 2'h2, 1'b1, 14'h0000);
    `CHK("cond_ret", 14'h0300, pc)
    irq_enable = 7'h7f;
    irq_mask_all = 1'b1;
    irq_req = 8'h08;
    irq_try(8'h00, pc);
    irq_req = 8'h01;
    irq_try(8'h01, 14'h0000);
    init_req = 1'b1;
    irq_try(8'h01, 14'h0000);
    power_up_det = 1'b1;
    irq_try(8'h01, 14'h0000);
    irq_mask_all = 1'b0;
    irq_enable = 7'h7b;
    irq_req = 8'h08;
    irq_try(8'h00, pc);
    irq_enable = 7'h7f;
    irq_req = 8'h24;
    irq_try(8'h04, 14'h0010);
    for (i = 1; i < 8; i++) begin
      tgt = pc;
      irq_req = 8'h01 << i;
      irq_try(8'h01 << i, 14'(i) * 14'h0008);
      flow(FL_RET, 1'b0, 2'h0, 1'b0, 14'h0000);
      `CHK("resume", tgt, pc)
    end
    rtc_to_level7 = 1'b1;
    irq_try(8'h80, 14'h0038);
    for (k = 0; k < 2; k++) begin
      rtc_use_default = k[0];
      {t0, t1} = 0;
      for (i = 0; i < 50; i++) begin
        step();
        if (rtc_tick_out === 1'b1) begin
          t0 = t1;
          t1 = i;
        end
      end
      `CHK("tick_gap", k ? RTC_SIM : 10, t1 - t0)
    end
    `CHK("rtc_cycles", 200000, RTC_CYCLES)
    give_verdict();
  end
endmodule
`default_nettype wire
